/* File: hw/twcb_crc8.sv */
`timescale 1ns/1ps
module twcb_crc8
  import twcb_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       clr,
  input  wire logic       byte_vld,
  input  wire logic [7:0] byte_in,
  output logic      [7:0] crc,
  output logic            load
);
  logic [7:0] stage [0:8];

  // one shift stage per data bit, msb first
  assign stage[0] = crc;
  genvar i;
  generate
    for (i = 0; i < 8; i++)
    begin : g_bit
      assign stage[i+1] = {stage[i][6:0], 1'b0} ^
        ((stage[i][7] ^ byte_in[7-i]) ? CRC_POLY : 8'h00);
    end
  endgenerate

  // running crc over the packet, cleared at start
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      crc <= CRC_INIT;
    else if (clr)
      crc <= CRC_INIT;
    else if (byte_vld)
      crc <= stage[8];
  end

  // result is usable the cycle after the update
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      load <= 1'b0;
    else
      load <= byte_vld & ~clr;
  end
endmodule

/* File: hw/twcb_top.sv */
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
// Contract
// - crc reads valid while enabled and ready
// - crc per byte, then ready flag set
// - reading crc register clears ready
// - hardware clears ready before next load
// - rate code selects divisor 20 to 2560
// - arbitration loss releases both lines
// - busy stays set until stop seen
// - disabling releases bus, clears busy
// - re-enabling resumes normal operation
module twcb_top
  import twcb_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        SYS_RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        SCL_IN,
  output logic             SCL_OUT,
  output logic             SCL_OE_N,
  input  wire logic        SDA_IN,
  output logic             SDA_OUT,
  output logic             SDA_OE_N,
  output logic             IRQ
);
  logic        en_q, mst_q, tx_empty_q, crc_ready_q, busy_q;
  logic [2:0]  sel_q;
  logic [7:0]  txd_q, shift_q, rx_q;
  logic [3:0]  mask_q;
  twcb_evt_t   ints_q, evt;
  twcb_stat_t  stat;
  twcb_state_t st_q;
  logic [11:0] cnt_q, half_cnt;
  logic [3:0]  bit_q, mon_cnt_q;
  logic        scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
  logic        wr_acc, rd_acc, setup, rd_crc, map_ok, tick;
  logic        start_det, stop_det, scl_rise, byte_vld, crc_load, arb_ev;
  logic        ld_ev;
  logic [7:0]  crc_val;

  // apb decode
  assign setup  = PSEL & ~PENABLE;
  assign wr_acc = PSEL & PENABLE & PREADY & PWRITE;
  assign rd_acc = PSEL & PENABLE & PREADY & ~PWRITE;
  assign rd_crc = rd_acc & (PADDR == ADDR_CRC);
  assign map_ok = PADDR inside {ADDR_CTRL, ADDR_DIV, ADDR_TXD, ADDR_CRC,
                                ADDR_STAT, ADDR_INTS, ADDR_INTM};
  assign stat   = '{master: mst_q, tx_empty: tx_empty_q,
                    crc_ready: crc_ready_q, busy: busy_q};

  // no wait state: answer in the first access cycle
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end
    else
    begin
      PREADY  <= setup;
      PSLVERR <= setup & ~map_ok;
    end
  end

  // read data captured in the setup cycle
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      PRDATA <= 32'h0000_0000;
    else if (setup & ~PWRITE)
    begin
      unique case (PADDR)
        ADDR_CTRL: PRDATA <= {30'h0, mst_q, en_q};
        ADDR_DIV:  PRDATA <= {29'h0, sel_q};
        ADDR_TXD:  PRDATA <= {24'h0, txd_q};
        ADDR_CRC:  PRDATA <= {24'h0, (en_q & crc_ready_q) ? crc_val
                                                          : 8'h00};
        ADDR_STAT: PRDATA <= {28'h0, stat};
        ADDR_INTS: PRDATA <= {28'h0, ints_q};
        ADDR_INTM: PRDATA <= {28'h0, mask_q};
        default:   PRDATA <= 32'h0000_0000;
      endcase
    end
  end

  // enable, rate select and mask registers
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      en_q   <= 1'b0;
      sel_q  <= DIV_RST;
      mask_q <= MASK_RST;
    end
    else if (wr_acc)
    begin
      if (PADDR == ADDR_CTRL)
        en_q <= PWDATA[CTRL_EN_BIT];
      if (PADDR == ADDR_DIV)
        sel_q <= PWDATA[DIV_SEL_W-1:0];
      if (PADDR == ADDR_INTM)
        mask_q <= PWDATA[3:0];
    end
  end

  // master request: cleared by software, loss or disable
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      mst_q <= 1'b0;
    else if (~en_q | arb_ev)
      mst_q <= 1'b0;
    else if (wr_acc && PADDR == ADDR_CTRL)
      mst_q <= PWDATA[CTRL_MST_BIT];
  end

  // transmit holding register
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      txd_q      <= 8'h00;
      tx_empty_q <= 1'b1;
    end
    else if (wr_acc && PADDR == ADDR_TXD)
    begin
      txd_q      <= PWDATA[7:0];
      tx_empty_q <= 1'b0;
    end
    else if (~en_q | ld_ev)
      tx_empty_q <= 1'b1;
  end

  // pin synchronisers and edge history
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      {scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
      {sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
    end
    else
    begin
      {scl_m_q, scl_s_q, scl_p_q} <= {SCL_IN, scl_m_q, scl_s_q};
      {sda_m_q, sda_s_q, sda_p_q} <= {SDA_IN, sda_m_q, sda_s_q};
    end
  end

  assign start_det = en_q & scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  assign stop_det  = en_q & scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
  assign scl_rise  = en_q & scl_s_q & ~scl_p_q;
  assign byte_vld  = scl_rise & (mon_cnt_q == 4'h7);

  // bus monitor: every byte on the bus, sent or received
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      mon_cnt_q <= 4'h0;
      rx_q      <= 8'h00;
    end
    else if (start_det | ~en_q)
      mon_cnt_q <= 4'h0;
    else if (scl_rise)
    begin
      mon_cnt_q <= (mon_cnt_q == ACK_BIT) ? 4'h0 : mon_cnt_q + 4'h1;
      if (mon_cnt_q != ACK_BIT)
        rx_q <= {rx_q[6:0], sda_s_q};
    end
  end

  // bus busy from start until stop or disable
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      busy_q <= 1'b0;
    else if (~en_q)
      busy_q <= 1'b0;
    else if (start_det)
      busy_q <= 1'b1;
    else if (stop_det)
      busy_q <= 1'b0;
  end

  // packet crc, restarted at each start
  twcb_crc8 i_twcb_crc8 (
    .clk      (SYS_CLK),
    .rst      (SYS_RST),
    .clr      (start_det | ~en_q),
    .byte_vld (byte_vld),
    .byte_in  ({rx_q[6:0], sda_s_q}),
    .crc      (crc_val),
    .load     (crc_load)
  );

  // ready flag: disable clears first, load beats read or next byte
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      crc_ready_q <= 1'b0;
    else if (~en_q)
      crc_ready_q <= 1'b0;
    else if (crc_load)
      crc_ready_q <= 1'b1;
    else if (byte_vld | rd_crc)
      crc_ready_q <= 1'b0;
  end

  // half-period count from the rate select code
  assign half_cnt = HALF_BASE << sel_q;
  assign tick     = (cnt_q == 12'h000);

  // baud timer, stalled while scl is stretched high phase
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      cnt_q <= 12'h000;
    else if (st_q == ST_IDLE || st_q == ST_WAIT || tick)
      cnt_q <= half_cnt - 12'h001;
    else if (st_q != ST_HIGH || scl_s_q)
      cnt_q <= cnt_q - 12'h001;
  end

  assign ld_ev  = en_q & ~tx_empty_q & ((st_q == ST_IDLE & mst_q & ~busy_q)
                | (st_q == ST_WAIT) | (st_q == ST_HIGH & tick &
                  bit_q == ACK_BIT & ~arb_ev));
  assign arb_ev = en_q & (st_q == ST_HIGH) & tick & (bit_q != ACK_BIT)
                & SDA_OE_N & ~sda_s_q;

  // master byte sender
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      st_q     <= ST_IDLE;
      bit_q    <= 4'h0;
      shift_q  <= 8'h00;
      SCL_OE_N <= 1'b1;
      SDA_OE_N <= 1'b1;
    end
    else if (~en_q)
    begin
      st_q     <= ST_IDLE;
      SCL_OE_N <= 1'b1;
      SDA_OE_N <= 1'b1;
    end
    else if (arb_ev)
    begin
      st_q     <= ST_IDLE;
      SCL_OE_N <= 1'b1;
      SDA_OE_N <= 1'b1;
    end
    else
    begin
      unique case (st_q)
        ST_IDLE:
          if (ld_ev)
          begin
            shift_q  <= txd_q;
            SDA_OE_N <= 1'b0;
            st_q     <= ST_START;
          end
        ST_START:
          if (tick)
          begin
            SCL_OE_N <= 1'b0;
            SDA_OE_N <= shift_q[7];
            bit_q    <= 4'h0;
            st_q     <= ST_LOW;
          end
        ST_LOW:
          if (tick)
          begin
            SCL_OE_N <= 1'b1;
            st_q     <= ST_HIGH;
          end
        ST_HIGH:
          if (tick)
          begin
            SCL_OE_N <= 1'b0;
            if (bit_q != ACK_BIT)
            begin
              bit_q    <= bit_q + 4'h1;
              shift_q  <= {shift_q[6:0], 1'b0};
              SDA_OE_N <= (bit_q == 4'h7) ? 1'b1 : shift_q[6];
              st_q     <= ST_LOW;
            end
            else if (ld_ev)
            begin
              shift_q  <= txd_q;
              bit_q    <= 4'h0;
              SDA_OE_N <= txd_q[7];
              st_q     <= ST_LOW;
            end
            else if (~mst_q)
            begin
              SDA_OE_N <= 1'b0;
              bit_q    <= 4'h0;
              st_q     <= ST_STOP;
            end
            else
              st_q <= ST_WAIT;
          end
        ST_WAIT:
          if (ld_ev)
          begin
            shift_q  <= txd_q;
            bit_q    <= 4'h0;
            SDA_OE_N <= txd_q[7];
            st_q     <= ST_LOW;
          end
          else if (~mst_q)
          begin
            SDA_OE_N <= 1'b0;
            bit_q    <= 4'h0;
            st_q     <= ST_STOP;
          end
        ST_STOP:
          if (tick)
          begin
            if (bit_q == 4'h0)
            begin
              SCL_OE_N <= 1'b1;
              bit_q    <= 4'h1;
            end
            else
            begin
              SDA_OE_N <= 1'b1;
              st_q     <= ST_IDLE;
            end
          end
      endcase
    end
  end

  // open-drain lines only ever pull low
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      SCL_OUT <= 1'b0;
      SDA_OUT <= 1'b0;
    end
    else
    begin
      SCL_OUT <= 1'b0;
      SDA_OUT <= 1'b0;
    end
  end

  assign evt = '{stop_seen: stop_det, byte_done: scl_rise &
                 (mon_cnt_q == ACK_BIT), arb_lost: arb_ev,
                 crc_ready: crc_load};

  // sticky events, cleared by a read; a new event wins
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      ints_q <= '0;
    else if (rd_acc && PADDR == ADDR_INTS)
      ints_q <= evt;
    else
      ints_q <= ints_q | evt;
  end

  // level interrupt from unmasked events
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      IRQ <= 1'b0;
    else
      IRQ <= |(ints_q & mask_q);
  end

  chk_crc_read: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    setup & ~PWRITE & (PADDR == ADDR_CTRL + 8'h0c) |=>
      PRDATA == {24'h0, ($past(en_q) & $past(crc_ready_q))
                        ? $past(crc_val) : 8'h00})
    else $error("crc read data wrong");
  chk_crc_load: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    byte_vld & ~start_det ##1 en_q |=> crc_ready_q)
    else $error("crc ready not set after byte");
  chk_read_clear: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    rd_crc & ~crc_load |=> ~crc_ready_q)
    else $error("crc read did not clear ready");
  chk_hw_clear: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    byte_vld ##1 en_q |-> ~crc_ready_q ##1 crc_ready_q)
    else $error("ready not cleared before load");
  chk_div_rate: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    st_q == ST_LOW && tick |=> cnt_q == (12'h00a << sel_q) - 12'h001)
    else $error("divider reload wrong");
  chk_arb_release: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    arb_ev |=> SCL_OE_N && SDA_OE_N && st_q == ST_IDLE && !mst_q)
    else $error("lines not released on loss");
  chk_busy_hold: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    busy_q && en_q && !stop_det |=> busy_q)
    else $error("busy dropped without stop");
  chk_disable_clr: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    !en_q |=> !busy_q && SCL_OE_N && SDA_OE_N && !crc_ready_q)
    else $error("disable did not release bus");
endmodule

/* File: include/twcb_pkg.sv */
package twcb_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DIV  = 8'h04;
  localparam logic [7:0] ADDR_TXD  = 8'h08;
  localparam logic [7:0] ADDR_CRC  = 8'h0c;
  localparam logic [7:0] ADDR_STAT = 8'h10;
  localparam logic [7:0] ADDR_INTS = 8'h14;
  localparam logic [7:0] ADDR_INTM = 8'h18;

  // control fields
  localparam int CTRL_EN_BIT  = 0;
  localparam int CTRL_MST_BIT = 1;
  localparam int DIV_SEL_W    = 3;

  // reset values
  localparam logic [2:0] DIV_RST  = 3'h0;
  localparam logic [7:0] CRC_RST  = 8'h00;
  localparam logic [3:0] MASK_RST = 4'h0;

  // crc-8, x^8+x^2+x+1
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;

  // half of the smallest divisor (20), doubled per select code
  localparam logic [11:0] HALF_BASE = 12'h00a;
  localparam logic [3:0]  ACK_BIT   = 4'h8;

  // status word layout
  typedef struct packed {
    logic master;
    logic tx_empty;
    logic crc_ready;
    logic busy;
  } twcb_stat_t;

  // interrupt event layout
  typedef struct packed {
    logic stop_seen;
    logic byte_done;
    logic arb_lost;
    logic crc_ready;
  } twcb_evt_t;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_START = 6'b000010,
    ST_LOW   = 6'b000100,
    ST_HIGH  = 6'b001000,
    ST_WAIT  = 6'b010000,
    ST_STOP  = 6'b100000
  } twcb_state_t;
endpackage

/* File: verification/twcb_far_end.sv */
`timescale 1ns/1ps
module twcb_far_end
(
  input  wire logic scl_oe_n,
  input  wire logic scl_out,
  input  wire logic sda_oe_n,
  input  wire logic sda_out,
  output wire logic scl,
  output wire logic sda
);
  logic scl_low = 1'b0;
  logic sda_low = 1'b0;

  // open-drain lines, pulled up when nobody drives
  assign scl = (scl_oe_n | scl_out) & ~scl_low;
  assign sda = (sda_oe_n | sda_out) & ~sda_low;

  // hold data low, a rival master winning arbitration
  task hold_sda(input logic v);
    sda_low <= v;
  endtask

  // one bit, 125 ns link period, clock only inside frames
  task send_bit(input logic b);
    sda_low = ~b;
    #31.25 scl_low = 1'b0;
    #62.5 scl_low = 1'b1;
    #31.25;
  endtask

  // start, bytes msb first with a released ack slot, stop
  task frame(input logic [15:0] d, input int nb);
    #1.3 sda_low = 1'b1;
    #62.5 scl_low = 1'b1;
    for (int i = 0; i < 8 * nb; i++)
    begin
      send_bit(d[15 - i]);
      if (i % 8 == 7)
        send_bit(1'b1);
    end
    sda_low = 1'b1;
    #31.25 scl_low = 1'b0;
    #31.25 sda_low = 1'b0;
  endtask
endmodule

/* File: verification/twcb_top_test.sv */
`timescale 1ns/1ps
module twcb_top_test;
  import twcb_pkg::*;

  logic        clk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        scl;
  logic        sda;
  logic        scl_out;
  logic        scl_oe_n;
  logic        sda_out;
  logic        sda_oe_n;
  logic        irq;
  logic [31:0] rd;
  logic        er;
  int          bad_count = 0;
  int          compares = 0;
  int          cycles = 0;

  twcb_top i_twcb_top (
    .SYS_CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .SCL_IN(scl), .SCL_OUT(scl_out),
    .SCL_OE_N(scl_oe_n), .SDA_IN(sda), .SDA_OUT(sda_out),
    .SDA_OE_N(sda_oe_n), .IRQ(irq)
  );

  twcb_far_end i_twcb_far_end (
    .scl_oe_n(scl_oe_n), .scl_out(scl_out), .sda_oe_n(sda_oe_n),
    .sda_out(sda_out), .scl(scl), .sda(sda)
  );

  // system clock, 5 ns period
  always #2.5 clk = ~clk;

  // hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 80000)
    begin
      bad_count++;
      results();
    end
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  // one apb transfer, request held until pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // read a register until the masked bits match
  task poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    int n;
    n = 0;
    do
    begin
      apb(1'b0, a, 32'h0);
      n++;
    end
    while ((rd & m) !== v && n < 30000);
    chk(rd & m, v);
  endtask

  // reference crc-8, msb first
  function automatic logic [7:0] crc8(input logic [7:0] c,
                                      input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int i = 0; i < 8; i++)
      r = r[7] ? {r[6:0], 1'b0} ^ CRC_POLY : {r[6:0], 1'b0};
    return r;
  endfunction

  // length of the first scl low phase driven by the master
  task hlen(input logic pull, output int cnt);
    cnt = 0;
    while (scl_oe_n !== 1'b0 && cnt < 9000)
    begin
      @(posedge clk);
      cnt++;
    end
    if (pull)
      i_twcb_far_end.hold_sda(1'b1);
    cnt = 0;
    while (scl_oe_n === 1'b0 && cnt < 9000)
    begin
      @(posedge clk);
      cnt++;
    end
  endtask

  task t_regs;
    apb(1'b0, ADDR_DIV, 32'h0);
    chk(rd, {29'h0, DIV_RST});
    for (int c = 0; c < 8; c++)
    begin
      apb(1'b1, ADDR_DIV, 32'(c));
      apb(1'b0, ADDR_DIV, 32'h0);
      chk(rd, 32'(c));
    end
    apb(1'b0, 8'h1c, 32'h0);
    chk({er, rd[30:0]}, 32'h80000000);
    apb(1'b0, ADDR_CRC, 32'h0);
    chk(rd, 32'h0);
    $display("registers done");
  endtask

  task t_rx;
    apb(1'b1, ADDR_INTM, 32'h0);
    apb(1'b1, ADDR_CTRL, 32'h1);
    i_twcb_far_end.frame(16'ha500, 1);
    poll(ADDR_STAT, 32'h3, 32'h2);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, ADDR_INTM, 32'h1);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, ADDR_CRC, 32'h0);
    chk(rd, {24'h0, crc8(CRC_INIT, 8'ha5)});
    apb(1'b0, ADDR_STAT, 32'h0);
    chk(rd & 32'h2, 32'h0);
    apb(1'b0, ADDR_CRC, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, ADDR_INTS, 32'h0);
    chk(rd & 32'hf, 32'hd);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    i_twcb_far_end.frame(16'h3c5a, 2);
    poll(ADDR_STAT, 32'h2, 32'h2);
    apb(1'b0, ADDR_CRC, 32'h0);
    chk(rd, {24'h0, crc8(crc8(CRC_INIT, 8'h3c), 8'h5a)});
    $display("receive crc done");
  endtask

  task t_mst;
    int h;
    logic [7:0] p;
    apb(1'b1, ADDR_DIV, 32'h7);
    apb(1'b1, ADDR_TXD, 32'h96);
    apb(1'b1, ADDR_CTRL, 32'h3);
    hlen(1'b0, h);
    chk(32'(h), 32'd1280);
    poll(ADDR_STAT, 32'h2, 32'h2);
    apb(1'b0, ADDR_CRC, 32'h0);
    p = rd[7:0];
    chk({24'h0, p}, {24'h0, crc8(CRC_INIT, 8'h96)});
    apb(1'b1, ADDR_TXD, {24'h0, p});
    apb(1'b1, ADDR_CTRL, 32'h1);
    poll(ADDR_STAT, 32'h3, 32'h2);
    apb(1'b0, ADDR_CRC, 32'h0);
    chk(rd, 32'h0);
    $display("master crc done");
  endtask

  task t_arb;
    int h;
    apb(1'b1, ADDR_DIV, 32'h0);
    apb(1'b1, ADDR_INTM, 32'h2);
    apb(1'b1, ADDR_TXD, 32'hff);
    apb(1'b1, ADDR_CTRL, 32'h3);
    hlen(1'b1, h);
    chk(32'(h), 32'd10);
    poll(ADDR_STAT, 32'h8, 32'h0);
    repeat (40) @(posedge clk);
    chk({30'h0, scl_oe_n, sda_oe_n}, 32'h3);
    chk({30'h0, scl_out, sda_out}, 32'h0);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk(rd & 32'h9, 32'h1);
    apb(1'b0, ADDR_INTS, 32'h0);
    chk(rd & 32'h2, 32'h2);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    // software timeout expired: disable to recover
    apb(1'b1, ADDR_CTRL, 32'h0);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk(rd & 32'h1, 32'h0);
    chk({30'h0, scl_oe_n, sda_oe_n}, 32'h3);
    i_twcb_far_end.hold_sda(1'b0);
    apb(1'b1, ADDR_CTRL, 32'h1);
    apb(1'b1, ADDR_TXD, 32'h0);
    apb(1'b1, ADDR_CTRL, 32'h3);
    hlen(1'b0, h);
    chk(32'(h), 32'd10);
    apb(1'b1, ADDR_CTRL, 32'h1);
    poll(ADDR_STAT, 32'h1, 32'h0);
    $display("arbitration recovery done");
  endtask

  task results;
    $display("comparisons %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // reset for 20 cycles, then the scenarios
  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_rx();
    t_mst();
    t_arb();
    results();
  end
endmodule
